// ### bench/test_tpd_pause_detector.sv
// self-checking testbench for the tape pause detector
`timescale 1ns/1ps
`define CHK(name, exp, got) begin \
  n_checks++; \
  if ((got) !== (exp)) begin \
    n_mismatch++; \
    $display("unexpected %s: expected %0h seen %0h", name, exp, got); \
  end \
end

module test_tpd_pause_detector;
  localparam int unsigned OSC = 4;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic audio_pulse, detect_en, mode_a, mode_b, gap_inv;
  logic want_audio = 1'b0;
  logic want_en = 1'b0;
  logic want_a = 1'b0;
  logic want_b = 1'b0;
  logic gap_out_q, phase_flag_q, divider_top_stage_q, program_found_q;
  int n_mismatch = 0;
  int n_checks = 0;

  always #4 clk_sys = ~clk_sys;

  tpd_deck_model DECK (.clk_sys(clk_sys), .want_audio(want_audio), .want_en(want_en),
    .want_a(want_a), .want_b(want_b), .audio_pulse(audio_pulse), .detect_en(detect_en),
    .mode_a(mode_a), .mode_b(mode_b), .gap_out_q(gap_out_q));
  tpd_pause_detector #(.OSC_CYCLES(OSC), .OUT_INVERT(1'b0)) DUT (.clk_sys(clk_sys), .rst(rst),
    .audio_pulse(audio_pulse), .detect_en(detect_en), .mode_a(mode_a), .mode_b(mode_b),
    .gap_out_q(gap_out_q), .phase_flag_q(phase_flag_q),
    .divider_top_stage_q(divider_top_stage_q), .program_found_q(program_found_q));
  // inverted variant on the same pins; only its output is compared
  tpd_pause_detector #(.OSC_CYCLES(OSC), .OUT_INVERT(1'b1)) DUT_INV (.clk_sys(clk_sys),
    .rst(rst), .audio_pulse(audio_pulse), .detect_en(detect_en), .mode_a(mode_a),
    .mode_b(mode_b), .gap_out_q(gap_inv), .phase_flag_q(), .divider_top_stage_q(),
    .program_found_q());

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // new pins, then time for the synchroniser and the mode latch to settle
  task automatic set_pins(input logic en, input logic a, input logic b);
    @(negedge clk_sys);
    want_en = en;
    want_a = a;
    want_b = b;
    repeat (6) @(negedge clk_sys);
  endtask

  // three clocks high, three low: wider than the one-clock pulse the detector takes
  task automatic burst(input int n);
    repeat (n) begin
      @(negedge clk_sys);
      want_audio = 1'b1;
      repeat (3) @(negedge clk_sys);
      want_audio = 1'b0;
      repeat (2) @(negedge clk_sys);
    end
    repeat (4) @(negedge clk_sys);
  endtask

  // steady audio, as music during a gap search
  task automatic tone(input int n);
    @(negedge clk_sys);
    want_audio = 1'b1;
    repeat (n) @(negedge clk_sys);
    want_audio = 1'b0;
  endtask

  task automatic chk_state(input logic ph, input logic top, input logic fnd, input logic act);
    `CHK("phase flag", ph, phase_flag_q)
    `CHK("top stage", top, divider_top_stage_q)
    `CHK("program found", fnd, program_found_q)
    `CHK("gap output", act, gap_out_q)
    `CHK("inverted output", ~act, gap_inv)
  endtask

  // wait for the gap pulse, then time it; lo and hi bound the silent span
  task automatic measure_gap(input int lo, input int hi);
    int n;
    int hits;
    n = 0;
    hits = DECK.plunger_hits;
    while (gap_out_q !== 1'b1 && n < hi + 64) begin
      @(negedge clk_sys);
      n++;
    end
    `CHK("silent span", 1'b1, n >= lo && n <= hi)
    chk_state(1'b1, 1'b1, 1'b1, 1'b1);
    n = 0;
    while (gap_out_q === 1'b1 && n < 512 * OSC) begin
      @(negedge clk_sys);
      n++;
    end
    `CHK("pulse width", 256 * OSC, n)
    chk_state(1'b0, 1'b0, 1'b0, 1'b0);
    `CHK("plunger hits", hits + 1, DECK.plunger_hits)
  endtask

  task automatic t_idle();
    set_pins(1'b0, 1'b0, 1'b1);
    burst(20);
    chk_state(1'b0, 1'b0, 1'b0, 1'b0);
    set_pins(1'b1, 1'b1, 1'b1);
    burst(20);
    chk_state(1'b0, 1'b0, 1'b0, 1'b0);
    set_pins(1'b1, 1'b0, 1'b0);
    burst(20);
    chk_state(1'b0, 1'b0, 1'b0, 1'b0);
    $display("test idle finished");
  endtask

  task automatic t_play();
    set_pins(1'b1, 1'b0, 1'b1);
    burst(3711);
    chk_state(1'b0, 1'b0, 1'b0, 1'b0);
    burst(1);
    chk_state(1'b0, 1'b1, 1'b0, 1'b0);
    burst(255);
    chk_state(1'b0, 1'b1, 1'b0, 1'b0);
    burst(1);
    chk_state(1'b1, 1'b0, 1'b1, 1'b0);
    // audio part way into the silence must restart the count
    repeat (500 * OSC) @(negedge clk_sys);
    tone(8);
    measure_gap(3712 * OSC - 4, 3712 * OSC + 8);
    $display("test play finished");
  endtask

  task automatic t_fast();
    burst(300);
    set_pins(1'b1, 1'b1, 1'b0);
    burst(3500);
    chk_state(1'b0, 1'b0, 1'b0, 1'b0);
    burst(212);
    chk_state(1'b0, 1'b1, 1'b0, 1'b0);
    burst(256);
    chk_state(1'b1, 1'b0, 1'b1, 1'b0);
    measure_gap(128 * OSC - 12, 128 * OSC);
    $display("test fast wind finished");
  endtask

  // a short burst then silence: the count must not carry over
  task automatic t_noise();
    burst(100);
    repeat (200 * OSC) @(negedge clk_sys);
    chk_state(1'b0, 1'b0, 1'b0, 1'b0);
    burst(3620);
    chk_state(1'b0, 1'b0, 1'b0, 1'b0);
    // the first pulse after the long silence counts, so 92 more reach the threshold
    burst(92);
    chk_state(1'b0, 1'b1, 1'b0, 1'b0);
    $display("test noise finished");
  endtask

  initial begin
    repeat (3) @(negedge clk_sys);
    rst = 1'b0;
    chk_state(1'b0, 1'b0, 1'b0, 1'b0);
    t_idle();
    t_play();
    t_fast();
    t_noise();
    summarize();
  end

  // watchdog: the tests need about 93000 clocks
  initial begin
    #(100000 * 8);
    n_mismatch++;
    $display("watchdog expired");
    summarize();
  end
endmodule

// ### bench/tpd_deck_model.sv
// tape deck model: mode controller, audio source and plunger counter
`timescale 1ns/1ps

module tpd_deck_model (
  // clock
  input wire logic clk_sys,
  // levels the deck controller is asked to present
  input wire logic want_audio,
  input wire logic want_en,
  input wire logic want_a,
  input wire logic want_b,
  // pins toward the detector
  output logic audio_pulse,
  output logic detect_en,
  output logic mode_a,
  output logic mode_b,
  // plunger drive
  input wire logic gap_out_q
);
  int plunger_hits = 0;
  logic gap_d = 1'b0;
  // deck buffers pass the requested levels straight to the pins
  assign audio_pulse = want_audio;
  assign detect_en = want_en;
  assign mode_a = want_a;
  assign mode_b = want_b;
  // plunger fires once per output pulse; sampled away from the launching edge
  always @(negedge clk_sys) begin
    if (gap_out_q && !gap_d) begin
      plunger_hits++;
    end
    gap_d <= gap_out_q;
  end
endmodule

// ### bench/tpd_pause_monitor.sv
// assertion checker for the tape pause detector ports
`timescale 1ns/1ps

module tpd_pause_monitor #(
  parameter int unsigned OSC_CYCLES = 4,
  parameter bit OUT_INVERT = 1'b0
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // deck pins
  input wire logic audio_pulse,
  input wire logic detect_en,
  input wire logic mode_a,
  input wire logic mode_b,
  // outputs
  input wire logic gap_out_q,
  input wire logic phase_flag_q,
  input wire logic divider_top_stage_q,
  input wire logic program_found_q
);
  int unsigned width_exp;
  logic act;
  logic ok;
  logic [2:0] ok_cnt_q;
  logic [31:0] wid_cnt_q;
  logic aud_q;
  assign width_exp = 256 * OSC_CYCLES;
  assign act = gap_out_q ^ OUT_INVERT;
  assign ok = (ok_cnt_q == 3'h6);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // steady run: pins must settle past the synchroniser before timing is judged
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst || !detect_en || mode_a == mode_b || !$stable(mode_a) || !$stable(mode_b)) begin
      ok_cnt_q <= 3'h0;
    end else if (!ok) begin
      ok_cnt_q <= ok_cnt_q + 3'h1;
    end
  end
  // output pulse length, and whether audio cut it short
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst || !act) begin
      wid_cnt_q <= 32'h0;
      aud_q <= 1'b0;
    end else begin
      wid_cnt_q <= wid_cnt_q + 32'h1;
      aud_q <= aud_q | audio_pulse;
    end
  end
  chk_off_idle: assert property ((mode_a == mode_b) [*6] |-> !phase_flag_q && !divider_top_stage_q)
    else $error("active with mode off");
  chk_disable_idle: assert property ((!detect_en) [*6] |-> !phase_flag_q && !program_found_q && !act)
    else $error("active while disabled");
  chk_top_quiet: assert property ($rose(divider_top_stage_q) && !phase_flag_q |-> !act)
    else $error("output during program search");
  chk_program_seen: assert property (ok && $fell(divider_top_stage_q)
    && !$past(phase_flag_q) |-> phase_flag_q && program_found_q)
    else $error("no phase change after program");
  chk_gap_return: assert property (ok && $fell(act) && !aud_q |-> !phase_flag_q)
    else $error("no return to program search");
  chk_out_follows: assert property (act == (phase_flag_q && divider_top_stage_q))
    else $error("output not following top stage");
  chk_pulse_width: assert property (ok && $fell(act) && !aud_q |-> wid_cnt_q == width_exp)
    else $error("pulse width wrong");
  chk_found_clear: assert property ($fell(phase_flag_q) |-> !program_found_q)
    else $error("program flag kept");
  chk_audio_clears: assert property ((phase_flag_q && audio_pulse) [*4] |-> !divider_top_stage_q)
    else $error("audio did not clear count");
  cov_pulse: cover property (ok && $fell(act));
  cov_program: cover property ($rose(phase_flag_q));
  cov_restart: cover property ((phase_flag_q && audio_pulse) [*4]);
endmodule

bind tpd_pause_detector tpd_pause_monitor #(.OSC_CYCLES(OSC_CYCLES), .OUT_INVERT(OUT_INVERT)) u_mon (
  .clk_sys(clk_sys), .rst(rst), .audio_pulse(audio_pulse), .detect_en(detect_en),
  .mode_a(mode_a), .mode_b(mode_b), .gap_out_q(gap_out_q), .phase_flag_q(phase_flag_q),
  .divider_top_stage_q(divider_top_stage_q), .program_found_q(program_found_q));

// ### rtl/tpd_defines.svh
// constants for the tape pause detector: counts, timing and reset values
`ifndef TPD_DEFINES_SVH
`define TPD_DEFINES_SVH

// ****************************************************************
// counter geometry
// ****************************************************************
`define TPD_CNT_W 12
`define TPD_CNT_ZERO 12'h000
`define TPD_CNT_ONE 12'h001

// ****************************************************************
// divider thresholds, in counted events
// ****************************************************************
`define TPD_PROG_COUNT 12'he80
`define TPD_WIDTH_COUNT 12'h100
`define TPD_PLAY_GAP 12'he80
`define TPD_FAST_GAP 12'h080

// ****************************************************************
// reference oscillator timing
// ****************************************************************
`define TPD_TOSC_NS 864000
`define TPD_CLK_NS 8
`define TPD_OSC_CYCLES (`TPD_TOSC_NS / `TPD_CLK_NS)
`define TPD_OSC_W 20
`define TPD_OSC_ZERO 20'h00000
`define TPD_OSC_ONE 20'h00001

// ****************************************************************
// synchroniser lanes
// ****************************************************************
`define TPD_SYNC_W 4
`define TPD_SYNC_AUDIO 0
`define TPD_SYNC_EN 1
`define TPD_SYNC_MA 2
`define TPD_SYNC_MB 3
`define TPD_SYNC_ZERO 4'h0

`endif

// ### rtl/tpd_pause_detector.sv
// tape pause detector: program search and silent gap search on one divider
`timescale 1ns/1ps
`include "tpd_defines.svh"

module tpd_pause_detector
  import tpd_pkg::*;
#(
  parameter int unsigned OSC_CYCLES = `TPD_OSC_CYCLES,
  parameter bit OUT_INVERT = 1'b0
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // tape deck pins, asynchronous
  input wire logic audio_pulse,
  input wire logic detect_en,
  input wire logic mode_a,
  input wire logic mode_b,
  // drive to plunger or relay
  output logic gap_out_q,
  // status
  output logic phase_flag_q,
  output logic divider_top_stage_q,
  output logic program_found_q
);

  // ****************************************************************
  // pin synchronisation
  // ****************************************************************
  logic [`TPD_SYNC_W-1:0] pins_raw;
  logic [`TPD_SYNC_W-1:0] pins_sync;
  logic audio_s;
  logic enable_s;
  logic mode_a_s;
  logic mode_b_s;

  // pack the pins into lanes of one synchroniser
  assign pins_raw[`TPD_SYNC_AUDIO] = audio_pulse;
  assign pins_raw[`TPD_SYNC_EN] = detect_en;
  assign pins_raw[`TPD_SYNC_MA] = mode_a;
  assign pins_raw[`TPD_SYNC_MB] = mode_b;

  // all four pins share one synchroniser so they reach the logic in the same cycle
  tpd_sync #(
    .W(`TPD_SYNC_W)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .async_in(pins_raw),
    .sync_out(pins_sync)
  );

  assign audio_s = pins_sync[`TPD_SYNC_AUDIO];
  assign enable_s = pins_sync[`TPD_SYNC_EN];
  assign mode_a_s = pins_sync[`TPD_SYNC_MA];
  assign mode_b_s = pins_sync[`TPD_SYNC_MB];

  // ****************************************************************
  // mode decode and timing tap
  // ****************************************************************
  tpd_mode_t mode_now;
  tpd_mode_t mode_q;
  logic mode_changed;
  logic run;
  logic [`TPD_CNT_W-1:0] gap_thresh;
  logic [`TPD_CNT_W-1:0] gap_end;
  logic [`TPD_CNT_W-1:0] prog_end;

  // equal pins mean off, so run stays low and the divider, silence count and flags below are held clear
  always_comb begin
    unique case ({mode_a_s, mode_b_s})
      2'b10: mode_now = TPD_MODE_FAST;
      2'b01: mode_now = TPD_MODE_PLAY;
      default: mode_now = TPD_MODE_OFF;
    endcase
  end

  // remember the mode to spot any switch
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode_q <= TPD_MODE_OFF;
    end else begin
      mode_q <= mode_now;
    end
  end

  // a switch restarts the whole sequence, not only play to fast wind
  // run drops for one cycle, long enough to clear every stage below
  assign mode_changed = (mode_now != mode_q);
  assign run = enable_s && (mode_now != TPD_MODE_OFF) && !mode_changed;

  // timing tap: only the silent threshold depends on the mode
  assign gap_thresh = (mode_now == TPD_MODE_FAST) ? `TPD_FAST_GAP : `TPD_PLAY_GAP;
  assign gap_end = gap_thresh + `TPD_WIDTH_COUNT;
  assign prog_end = `TPD_PROG_COUNT + `TPD_WIDTH_COUNT;

  // ****************************************************************
  // reference oscillator
  // ****************************************************************
  logic [`TPD_OSC_W-1:0] osc_cnt_q;
  logic osc_tick;

  // divide the system clock down to one tick per oscillator period
  assign osc_tick = (osc_cnt_q == `TPD_OSC_W'(OSC_CYCLES - 1));

  // free running so the period is the same in every phase
  // trade-off: a fixed divide of the system clock, so the period is exact but not tunable
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      osc_cnt_q <= `TPD_OSC_ZERO;
    end else if (osc_tick) begin
      osc_cnt_q <= `TPD_OSC_ZERO;
    end else begin
      osc_cnt_q <= osc_cnt_q + `TPD_OSC_ONE;
    end
  end

  // ****************************************************************
  // audio edge detection
  // ****************************************************************
  logic audio_d1_q;
  logic audio_rise;

  // edge taken from the second sync flop, never the first
  // resets low like the idle pin, so no false edge follows reset
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      audio_d1_q <= 1'b0;
    end else begin
      audio_d1_q <= audio_s;
    end
  end

  assign audio_rise = audio_s && !audio_d1_q;

  // ****************************************************************
  // silence watch during program search
  // ****************************************************************
  logic [`TPD_CNT_W-1:0] quiet_cnt_q;
  logic quiet_done;

  // a burst that stops short is dropped once the line stays quiet
  // the watch saturates at the threshold, so a long pause never wraps it
  assign quiet_done = (quiet_cnt_q >= gap_thresh);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      quiet_cnt_q <= `TPD_CNT_ZERO;
    end else if (!run || phase_flag_q || audio_s) begin
      quiet_cnt_q <= `TPD_CNT_ZERO;
    end else if (osc_tick && !quiet_done) begin
      quiet_cnt_q <= quiet_cnt_q + `TPD_CNT_ONE;
    end
  end

  // ****************************************************************
  // divider chain next state
  // ****************************************************************
  logic [`TPD_CNT_W-1:0] div_cnt_q;
  logic [`TPD_CNT_W-1:0] div_cnt_d;
  logic top_d;
  logic top_fall;
  logic [`TPD_CNT_W-1:0] div_inc;
  tpd_phase_t phase_now;

  assign phase_now = phase_flag_q ? TPD_PH_GAP : TPD_PH_PROGRAM;
  assign div_inc = div_cnt_q + `TPD_CNT_ONE;

  // phase route: the phase decides clock source, reset and output use
  always_comb begin
    div_cnt_d = div_cnt_q;
    top_d = divider_top_stage_q;
    top_fall = 1'b0;
    if (!run) begin
      div_cnt_d = `TPD_CNT_ZERO;
      top_d = 1'b0;
    end else begin
      unique case (phase_now)
        TPD_PH_PROGRAM: begin
          if (quiet_done && !divider_top_stage_q) begin
            // the burst so far was noise; a pulse landing now opens a
            // fresh count, so it must not be swallowed by the clear
            if (audio_rise) begin
              div_cnt_d = `TPD_CNT_ONE;
            end else begin
              div_cnt_d = `TPD_CNT_ZERO;
            end
          end else if (audio_rise) begin
            div_cnt_d = div_inc;
            if (div_inc == `TPD_PROG_COUNT) begin
              top_d = 1'b1;
            end
            if (div_inc == prog_end) begin
              div_cnt_d = `TPD_CNT_ZERO;
              top_d = 1'b0;
              top_fall = 1'b1;
            end
          end
        end
        TPD_PH_GAP: begin
          if (audio_s) begin
            div_cnt_d = `TPD_CNT_ZERO;
            top_d = 1'b0;
          end else if (osc_tick) begin
            div_cnt_d = div_inc;
            if (div_inc == gap_thresh) begin
              top_d = 1'b1;
            end
            if (div_inc == gap_end) begin
              div_cnt_d = `TPD_CNT_ZERO;
              top_d = 1'b0;
              top_fall = 1'b1;
            end
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // divider chain and top stage
  // ****************************************************************
  // counter stages one to twelve
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      div_cnt_q <= `TPD_CNT_ZERO;
    end else begin
      div_cnt_q <= div_cnt_d;
    end
  end

  // top stage kept as its own flop so its fall is a clean event
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      divider_top_stage_q <= 1'b0;
    end else begin
      divider_top_stage_q <= top_d;
    end
  end

  // ****************************************************************
  // phase flag
  // ****************************************************************
  // low is program search; a counted fall of the top stage flips it
  // run low also covers detection off and both off modes
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      phase_flag_q <= 1'b0;
    end else if (!run) begin
      phase_flag_q <= 1'b0;
    end else if (top_fall) begin
      phase_flag_q <= !phase_flag_q;
    end
  end

  // ****************************************************************
  // program recognised status
  // ****************************************************************
  // high from recognition until the gap pulse ends or the block stops
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      program_found_q <= 1'b0;
    end else if (!run) begin
      program_found_q <= 1'b0;
    end else if (top_fall) begin
      program_found_q <= (phase_now == TPD_PH_PROGRAM);
    end
  end

  // ****************************************************************
  // output drive
  // ****************************************************************
  logic out_level;

  // top stage only reaches the pin in gap search; inactive otherwise
  assign out_level = run && (phase_now == TPD_PH_GAP) && top_d;

  // registered so polarity and timing match for both variants
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      gap_out_q <= OUT_INVERT;
    end else begin
      gap_out_q <= out_level ^ OUT_INVERT;
    end
  end

endmodule

// ### rtl/tpd_pkg.sv
// types shared by the tape pause detector files
package tpd_pkg;

  // operating mode decoded from the two mode pins
  typedef enum logic [1:0] {
    TPD_MODE_OFF,
    TPD_MODE_PLAY,
    TPD_MODE_FAST
  } tpd_mode_t;

  // phase flag: which source clocks the divider chain
  typedef enum logic {
    TPD_PH_PROGRAM,
    TPD_PH_GAP
  } tpd_phase_t;

endpackage

// ### rtl/tpd_sync.sv
// two-flop synchroniser, one lane per asynchronous pin
`timescale 1ns/1ps
`include "tpd_defines.svh"

module tpd_sync #(
  parameter int W = `TPD_SYNC_W
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // raw and synchronised levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  // ****************************************************************
  // per-lane double flop
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_lane
      logic meta_q;
      logic stab_q;
      // first flop feeds only the second one
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          meta_q <= 1'b0;
          stab_q <= 1'b0;
        end else begin
          meta_q <= async_in[gi];
          stab_q <= meta_q;
        end
      end
      assign sync_out[gi] = stab_q;
    end
  endgenerate

endmodule
